//--- hdl/cpubt_cfg.svh
// constants of the bit, transfer and control execution unit
`ifndef CPUBT_CFG_SVH
`define CPUBT_CFG_SVH
// status register bit positions
`define CPUBT_SR_C 0
`define CPUBT_SR_Z 1
`define CPUBT_SR_N 2
`define CPUBT_SR_V 3
`define CPUBT_SR_S 4
`define CPUBT_SR_H 5
`define CPUBT_SR_T 6
`define CPUBT_SR_I 7
// reset value of the status register
`define CPUBT_SR_RST 8'h00
// post-increment step of the program-memory store
`define CPUBT_PM_ZSTEP 16'h0002
`endif

//--- hdl/cpubt_exec.sv
// execution unit for transfer, bit, flag and control instructions
`timescale 1ns/1ns
`default_nettype none
`include "cpubt_cfg.svh"

// Functional notes
// - program store writes R1:R0 at page:Z, then Z advances by two
// - io in and io out move one byte in one cycle
// - push writes the register to the stack in one cycle
// - pop loads the register from the stack in two cycles
// - exchange swaps register and byte at Z, two cycles, flags kept
// - load-and-set returns old byte, writes register OR byte, two cycles
// - load-and-clear returns old byte, writes byte AND NOT register
// - load-and-toggle returns old byte, writes register XOR byte, two cycles
// - left shift/rotate: bit7 to carry, fill zero or carry, updates ZCNVH
// - right shift/rotate: bit0 to carry, fill zero or carry, updates ZCNV
// - arithmetic right shift keeps bit7, updates ZCNV, one cycle
// - io bit set/clear forces one io bit, one cycle, flags kept
// - bit store copies register bit into copy flag, one cycle
// - bit load copies copy flag into register bit, flags kept
// - flag set/clear writes only the selected status bit, one cycle
// - irq on sets and irq off clears the interrupt flag, one cycle
// - break, nop, sleep, watchdog restart take one cycle, flags kept
// - data memory counts hold for internal memory; external may stall
// - reads marked as internal-sram reads cost one extra cycle
module cpubt_exec (
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  // decoded instruction
  input wire logic I_VALID,
  input wire cpubt_pkg::cpubt_op_t I_OP,
  input wire logic [2:0] I_BIT_SEL,
  input wire logic [5:0] I_IO_ADDR,
  input wire logic [7:0] I_RD_DATA,
  // pointer and operand context
  input wire logic [15:0] I_Z,
  input wire logic [7:0] I_EXTENDED_Z_PAGE,
  input wire logic [15:0] I_R1R0,
  input wire logic [15:0] I_SP_ADDR,
  // io and data memory answers
  input wire logic [7:0] I_IO_RDATA,
  input wire logic [7:0] I_MEM_RDATA,
  input wire logic I_MEM_READY,
  input wire logic I_SRAM_XTRA,
  // sequencing and register file
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_RD_WE,
  output logic [7:0] O_RD_WDATA,
  output logic [7:0] O_STATUS_REGISTER,
  output logic O_Z_WE,
  output logic [15:0] O_Z_WDATA,
  // io space
  output logic O_IO_WE,
  output logic [5:0] O_IO_ADDR,
  output logic [7:0] O_IO_WDATA,
  // data memory and stack
  output logic O_MEM_RE,
  output logic O_MEM_WE,
  output logic [15:0] O_MEM_ADDR,
  output logic [7:0] O_MEM_WDATA,
  output logic O_SP_PUSH,
  output logic O_SP_POP,
  // program memory
  output logic O_PM_WE,
  output logic [23:0] O_PM_ADDR,
  output logic [15:0] O_PM_WDATA,
  // system requests
  output logic O_SLEEP_REQ,
  output logic O_BREAK_REQ,
  output logic O_WATCHDOG_RESTART_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  cpubt_pkg::cpubt_state_t state_reg;
  cpubt_pkg::cpubt_state_t state_next;
  cpubt_pkg::cpubt_op_t op_reg;
  logic [7:0] temp_reg;
  logic [7:0] mem_data_reg;
  logic xtra_reg;
  logic [7:0] flags_reg;
  logic issue;
  logic is_mem_read;
  logic finish;
  logic [7:0] old_byte;
  logic [7:0] wb_mem;
  logic [7:0] sh_res;
  logic sh_c;
  logic [7:0] io_bit_mask;

  // an instruction is taken only while idle, so a stalled read blocks issue
  assign issue = I_CE && I_VALID && (state_reg == cpubt_pkg::ST_IDLE);
  assign is_mem_read = (I_OP == cpubt_pkg::OP_POP) ||
                       (I_OP == cpubt_pkg::OP_MEMORY_EXCHANGE) ||
                       (I_OP == cpubt_pkg::OP_LOAD_AND_SET_MEMORY) ||
                       (I_OP == cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY) ||
                       (I_OP == cpubt_pkg::OP_LOAD_AND_TOGGLE_MEMORY);
  // internal ready without the extra cycle finishes in the second cycle, an extra-cycle or slow external one later
  assign finish = I_CE && (((state_reg == cpubt_pkg::ST_WAIT) && I_MEM_READY &&
                  !xtra_reg) || (state_reg == cpubt_pkg::ST_XTRA));
  assign old_byte = (state_reg == cpubt_pkg::ST_XTRA) ? mem_data_reg : I_MEM_RDATA;
  assign io_bit_mask = 8'h01 << I_BIT_SEL;

  // write-back byte of the read-modify-write group, built from old values
  always_comb begin
    case (op_reg)
      cpubt_pkg::OP_LOAD_AND_SET_MEMORY: wb_mem = temp_reg | old_byte;
      cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY: wb_mem = old_byte & ~temp_reg;
      cpubt_pkg::OP_LOAD_AND_TOGGLE_MEMORY: wb_mem = temp_reg ^ old_byte;
      default: wb_mem = temp_reg;
    endcase
  end

  // shifter result and carry out
  always_comb begin
    sh_c = I_RD_DATA[0];
    case (I_OP)
      cpubt_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        sh_res = {I_RD_DATA[6:0], 1'b0};
        sh_c = I_RD_DATA[7];
      end
      cpubt_pkg::OP_ROTATE_LEFT_CARRY: begin
        sh_res = {I_RD_DATA[6:0], flags_reg[`CPUBT_SR_C]};
        sh_c = I_RD_DATA[7];
      end
      cpubt_pkg::OP_LOGICAL_RIGHT_SHIFT: sh_res = {1'b0, I_RD_DATA[7:1]};
      cpubt_pkg::OP_ROTATE_RIGHT_CARRY:
        sh_res = {flags_reg[`CPUBT_SR_C], I_RD_DATA[7:1]};
      cpubt_pkg::OP_ARITH_RIGHT_SHIFT: sh_res = {I_RD_DATA[7], I_RD_DATA[7:1]};
      default: sh_res = {I_RD_DATA[3:0], I_RD_DATA[7:4]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpubt_pkg::ST_IDLE: begin
        if (issue && is_mem_read) begin
          state_next = cpubt_pkg::ST_WAIT;
        end
      end
      cpubt_pkg::ST_WAIT: begin
        if (I_MEM_READY) begin
          state_next = xtra_reg ? cpubt_pkg::ST_XTRA : cpubt_pkg::ST_IDLE;
        end
      end
      cpubt_pkg::ST_XTRA: state_next = cpubt_pkg::ST_IDLE;
      default: state_next = cpubt_pkg::ST_IDLE;
    endcase
  end

  // sequencer state and captured operands
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_reg <= cpubt_pkg::ST_IDLE;
      op_reg <= cpubt_pkg::OP_NOP;
      temp_reg <= 8'h00;
      mem_data_reg <= 8'h00;
      xtra_reg <= 1'b0;
      O_BUSY <= 1'b0;
    end else if (I_CE) begin
      state_reg <= state_next;
      O_BUSY <= (state_next != cpubt_pkg::ST_IDLE);
      if (issue) begin
        op_reg <= I_OP;
        temp_reg <= I_RD_DATA; // temporary copy of the register
        xtra_reg <= I_SRAM_XTRA;
      end
      if ((state_reg == cpubt_pkg::ST_WAIT) && I_MEM_READY) begin
        mem_data_reg <= I_MEM_RDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register: only flag-writing operations touch it
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      flags_reg <= `CPUBT_SR_RST;
    end else if (issue) begin
      case (I_OP)
        cpubt_pkg::OP_LOGICAL_LEFT_SHIFT, cpubt_pkg::OP_ROTATE_LEFT_CARRY,
        cpubt_pkg::OP_LOGICAL_RIGHT_SHIFT, cpubt_pkg::OP_ROTATE_RIGHT_CARRY,
        cpubt_pkg::OP_ARITH_RIGHT_SHIFT: begin
          flags_reg[`CPUBT_SR_C] <= sh_c;
          flags_reg[`CPUBT_SR_Z] <= (sh_res == 8'h00);
          flags_reg[`CPUBT_SR_N] <= sh_res[7];
          flags_reg[`CPUBT_SR_V] <= sh_res[7] ^ sh_c;
          if ((I_OP == cpubt_pkg::OP_LOGICAL_LEFT_SHIFT) ||
              (I_OP == cpubt_pkg::OP_ROTATE_LEFT_CARRY)) begin
            flags_reg[`CPUBT_SR_H] <= I_RD_DATA[3];
          end
        end
        cpubt_pkg::OP_BIT_TO_COPY_FLAG:
          flags_reg[`CPUBT_SR_T] <= I_RD_DATA[I_BIT_SEL];
        cpubt_pkg::OP_FLAG_SET: flags_reg[I_BIT_SEL] <= 1'b1;
        cpubt_pkg::OP_FLAG_CLEAR: flags_reg[I_BIT_SEL] <= 1'b0;
        cpubt_pkg::OP_GLOBAL_IRQ_ON: flags_reg[`CPUBT_SR_I] <= 1'b1;
        cpubt_pkg::OP_GLOBAL_IRQ_OFF: flags_reg[`CPUBT_SR_I] <= 1'b0;
        default: flags_reg <= flags_reg;
      endcase
    end
  end
  assign O_STATUS_REGISTER = flags_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register, memory and io outputs; strobes last one cycle, except the read request held while ready is low
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_DONE <= 1'b0;
      O_RD_WE <= 1'b0;
      O_RD_WDATA <= 8'h00;
      O_Z_WE <= 1'b0;
      O_Z_WDATA <= 16'h0000;
      O_IO_WE <= 1'b0;
      O_IO_ADDR <= 6'h00;
      O_IO_WDATA <= 8'h00;
      O_MEM_RE <= 1'b0;
      O_MEM_WE <= 1'b0;
      O_MEM_ADDR <= 16'h0000;
      O_MEM_WDATA <= 8'h00;
      O_SP_PUSH <= 1'b0;
      O_SP_POP <= 1'b0;
      O_PM_WE <= 1'b0;
      O_PM_ADDR <= 24'h00_0000;
      O_PM_WDATA <= 16'h0000;
      O_SLEEP_REQ <= 1'b0;
      O_BREAK_REQ <= 1'b0;
      O_WATCHDOG_RESTART_REQ <= 1'b0;
    end else if (I_CE) begin
      O_DONE <= finish || (issue && !is_mem_read);
      O_RD_WE <= 1'b0;
      O_Z_WE <= 1'b0;
      O_IO_WE <= 1'b0;
      O_MEM_RE <= 1'b0;
      O_MEM_WE <= 1'b0;
      O_SP_PUSH <= 1'b0;
      O_SP_POP <= 1'b0;
      O_PM_WE <= 1'b0;
      O_SLEEP_REQ <= issue && (I_OP == cpubt_pkg::OP_SLEEP);
      O_BREAK_REQ <= issue && (I_OP == cpubt_pkg::OP_BREAK);
      O_WATCHDOG_RESTART_REQ <= issue && (I_OP == cpubt_pkg::OP_WATCHDOG_RESTART);
      // read request stays up while external memory holds off ready
      if ((state_reg == cpubt_pkg::ST_WAIT) && !I_MEM_READY) begin
        O_MEM_RE <= 1'b1;
      end
      if (issue) begin
        case (I_OP)
          cpubt_pkg::OP_PROGRAM_MEMORY_STORE: begin
            O_PM_WE <= 1'b1;
            O_PM_ADDR <= {I_EXTENDED_Z_PAGE, I_Z};
            O_PM_WDATA <= I_R1R0;
            O_Z_WE <= 1'b1;
            O_Z_WDATA <= I_Z + `CPUBT_PM_ZSTEP;
          end
          cpubt_pkg::OP_IO_IN, cpubt_pkg::OP_LOGICAL_LEFT_SHIFT,
          cpubt_pkg::OP_LOGICAL_RIGHT_SHIFT, cpubt_pkg::OP_ROTATE_LEFT_CARRY,
          cpubt_pkg::OP_ROTATE_RIGHT_CARRY, cpubt_pkg::OP_ARITH_RIGHT_SHIFT,
          cpubt_pkg::OP_SWAP: begin
            O_RD_WE <= 1'b1;
            O_RD_WDATA <= (I_OP == cpubt_pkg::OP_IO_IN) ? I_IO_RDATA : sh_res;
          end
          cpubt_pkg::OP_IO_OUT: begin
            O_IO_WE <= 1'b1;
            O_IO_ADDR <= I_IO_ADDR;
            O_IO_WDATA <= I_RD_DATA;
          end
          cpubt_pkg::OP_IO_BIT_SET, cpubt_pkg::OP_IO_BIT_CLEAR: begin
            O_IO_WE <= 1'b1;
            O_IO_ADDR <= I_IO_ADDR;
            O_IO_WDATA <= (I_OP == cpubt_pkg::OP_IO_BIT_SET) ? (I_IO_RDATA | io_bit_mask) :
                          (I_IO_RDATA & ~io_bit_mask);
          end
          cpubt_pkg::OP_COPY_FLAG_TO_BIT: begin
            O_RD_WE <= 1'b1;
            O_RD_WDATA <= flags_reg[`CPUBT_SR_T] ? (I_RD_DATA | io_bit_mask) :
                          (I_RD_DATA & ~io_bit_mask);
          end
          cpubt_pkg::OP_PUSH: begin
            O_MEM_WE <= 1'b1;
            O_MEM_ADDR <= I_SP_ADDR;
            O_MEM_WDATA <= I_RD_DATA;
            O_SP_PUSH <= 1'b1;
          end
          cpubt_pkg::OP_POP: begin
            O_MEM_RE <= 1'b1;
            O_MEM_ADDR <= I_SP_ADDR;
            O_SP_POP <= 1'b1;
          end
          cpubt_pkg::OP_MEMORY_EXCHANGE, cpubt_pkg::OP_LOAD_AND_SET_MEMORY,
          cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY, cpubt_pkg::OP_LOAD_AND_TOGGLE_MEMORY: begin
            O_MEM_RE <= 1'b1;
            O_MEM_ADDR <= I_Z;
          end
          default: O_DONE <= 1'b1;
        endcase
      end
      // write-back of the two-cycle group: old byte to register
      if (finish) begin
        O_RD_WE <= 1'b1;
        O_RD_WDATA <= old_byte;
        O_MEM_WE <= (op_reg != cpubt_pkg::OP_POP);
        O_MEM_WDATA <= wb_mem;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST || !I_CE);

  sequence s_issue(cpubt_pkg::cpubt_op_t op);
    issue && (I_OP == op);
  endsequence
  sequence s_fast_read;
    (state_reg == cpubt_pkg::ST_WAIT) && I_MEM_READY && !xtra_reg;
  endsequence

  AST_PM_STORE: assert property (s_issue(cpubt_pkg::OP_PROGRAM_MEMORY_STORE) |=>
    O_PM_WE && O_Z_WE && (O_PM_ADDR == {$past(I_EXTENDED_Z_PAGE), $past(I_Z)}) &&
    (O_Z_WDATA == $past(I_Z) + `CPUBT_PM_ZSTEP)) else $error("program store wrong");
  AST_IO_IN: assert property (s_issue(cpubt_pkg::OP_IO_IN) |=>
    O_RD_WE && O_DONE && (O_RD_WDATA == $past(I_IO_RDATA))) else $error("io in wrong");
  AST_PUSH: assert property (s_issue(cpubt_pkg::OP_PUSH) |=>
    O_MEM_WE && O_SP_PUSH && O_DONE) else $error("push not one cycle");
  AST_POP: assert property (s_issue(cpubt_pkg::OP_POP) ##1 s_fast_read |=>
    O_DONE && O_RD_WE && !O_MEM_WE) else $error("pop not two cycles");
  AST_SET_MEM: assert property (s_issue(cpubt_pkg::OP_LOAD_AND_SET_MEMORY) ##1 s_fast_read
    |=> O_MEM_WE && (O_MEM_WDATA == ($past(I_MEM_RDATA) | temp_reg)) &&
    (O_RD_WDATA == $past(I_MEM_RDATA))) else $error("load and set wrong");
  AST_EXCHANGE_FLAGS: assert property (s_issue(cpubt_pkg::OP_MEMORY_EXCHANGE) |=>
    $stable(O_STATUS_REGISTER) [*2]) else $error("exchange changed flags");
  AST_LEFT_CARRY: assert property (s_issue(cpubt_pkg::OP_LOGICAL_LEFT_SHIFT) |=>
    (O_STATUS_REGISTER[`CPUBT_SR_C] == $past(I_RD_DATA[7])) && !O_RD_WDATA[0])
    else $error("left shift carry wrong");
  AST_ARITH_KEEP: assert property (s_issue(cpubt_pkg::OP_ARITH_RIGHT_SHIFT) |=>
    O_RD_WDATA[7] == $past(I_RD_DATA[7])) else $error("arith shift lost sign");
  // a second sleep issued back to back legally keeps the strobe up one more cycle
  AST_SLEEP_PULSE: assert property (s_issue(cpubt_pkg::OP_SLEEP) |=>
    O_SLEEP_REQ ##1 (!O_SLEEP_REQ || $past(issue && (I_OP == cpubt_pkg::OP_SLEEP))))
    else $error("sleep strobe not one cycle");
  AST_SRAM_XTRA: assert property ((state_reg == cpubt_pkg::ST_WAIT) && I_MEM_READY &&
    xtra_reg |=> !O_DONE ##1 O_DONE) else $error("sram extra cycle missing");

endmodule : cpubt_exec
`default_nettype wire

//--- hdl/cpubt_pkg.sv
// types of the bit, transfer and control execution unit
`default_nettype none
package cpubt_pkg;
  // decoded operation presented by the fetch stage
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_PROGRAM_MEMORY_STORE = 5'h01,
    OP_IO_IN = 5'h02,
    OP_IO_OUT = 5'h03,
    OP_PUSH = 5'h04,
    OP_POP = 5'h05,
    OP_MEMORY_EXCHANGE = 5'h06,
    OP_LOAD_AND_SET_MEMORY = 5'h07,
    OP_LOAD_AND_CLEAR_MEMORY = 5'h08,
    OP_LOAD_AND_TOGGLE_MEMORY = 5'h09,
    OP_LOGICAL_LEFT_SHIFT = 5'h0a,
    OP_LOGICAL_RIGHT_SHIFT = 5'h0b,
    OP_ROTATE_LEFT_CARRY = 5'h0c,
    OP_ROTATE_RIGHT_CARRY = 5'h0d,
    OP_ARITH_RIGHT_SHIFT = 5'h0e,
    OP_SWAP = 5'h0f,
    OP_IO_BIT_SET = 5'h10,
    OP_IO_BIT_CLEAR = 5'h11,
    OP_BIT_TO_COPY_FLAG = 5'h12,
    OP_COPY_FLAG_TO_BIT = 5'h13,
    OP_FLAG_SET = 5'h14,
    OP_FLAG_CLEAR = 5'h15,
    OP_GLOBAL_IRQ_ON = 5'h16,
    OP_GLOBAL_IRQ_OFF = 5'h17,
    OP_BREAK = 5'h18,
    OP_SLEEP = 5'h19,
    OP_WATCHDOG_RESTART = 5'h1a
  } cpubt_op_t;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_XTRA = 2'b10
  } cpubt_state_t;
endpackage : cpubt_pkg
`default_nettype wire

//--- tb/cpu_bit_transfer_control_ops_test.sv
// self-checking bench of the transfer, bit, flag and control execution unit
`timescale 1ns/1ns
`default_nettype none
`include "cpubt_cfg.svh"
module cpu_bit_transfer_control_ops_test;
  typedef struct packed {
    logic rd_we; logic [7:0] rd_d; logic [7:0] sr; logic mem_we; logic [7:0] mem_d;
    logic [15:0] mem_a; logic io_we; logic [5:0] io_a; logic [7:0] io_d; logic pm_we;
    logic [23:0] pm_a; logic [15:0] pm_d; logic z_we; logic [15:0] z_d; logic push;
    logic [2:0] req;
  } cpubt_obs_t;
  ////////////////////////////////////////////////////////////////////////////////
  logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_valid = 1'b0, i_mem_ready = 1'b1;
  logic i_sram_xtra = 1'b0;
  cpubt_pkg::cpubt_op_t i_op = cpubt_pkg::OP_NOP;
  logic [2:0] i_bit_sel = 3'h0;
  logic [5:0] i_io_addr = 6'h00;
  logic [7:0] i_rd_data = 8'h00, i_extended_z_page = 8'h00, i_io_rdata = 8'h00;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [15:0] i_z = 16'h0000, i_r1r0 = 16'h0000, i_sp_addr = 16'h0000;
  logic o_busy, o_done, o_rd_we, o_z_we, o_io_we, o_mem_re, o_mem_we, o_sp_push, o_sp_pop;
  logic o_pm_we, o_sleep_req, o_break_req, o_watchdog_restart_req;
  logic [7:0] o_rd_wdata, o_status_register, o_io_wdata, o_mem_wdata;
  logic [15:0] o_z_wdata, o_mem_addr, o_pm_wdata;
  logic [5:0] o_io_addr;
  logic [23:0] o_pm_addr;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  cpubt_obs_t exp_q[$];
  int due_q[$];
  logic [7:0] sr_m = 8'h00, rd_v, pg_v, iod_v, md_v;
  logic [15:0] z_v, r10_v, sp_v;
  logic [5:0] io_v;
  logic [2:0] bs_v;

  cpubt_exec DUT (.I_CLK(i_clk), .I_SRST(i_srst), .I_CE(i_ce), .I_VALID(i_valid),
    .I_OP(i_op), .I_BIT_SEL(i_bit_sel), .I_IO_ADDR(i_io_addr), .I_RD_DATA(i_rd_data),
    .I_Z(i_z), .I_EXTENDED_Z_PAGE(i_extended_z_page), .I_R1R0(i_r1r0), .I_SP_ADDR(i_sp_addr),
    .I_IO_RDATA(i_io_rdata), .I_MEM_RDATA(i_mem_rdata), .I_MEM_READY(i_mem_ready),
    .I_SRAM_XTRA(i_sram_xtra), .O_BUSY(o_busy), .O_DONE(o_done), .O_RD_WE(o_rd_we),
    .O_RD_WDATA(o_rd_wdata), .O_STATUS_REGISTER(o_status_register), .O_Z_WE(o_z_we),
    .O_Z_WDATA(o_z_wdata), .O_IO_WE(o_io_we), .O_IO_ADDR(o_io_addr), .O_IO_WDATA(o_io_wdata),
    .O_MEM_RE(o_mem_re), .O_MEM_WE(o_mem_we), .O_MEM_ADDR(o_mem_addr),
    .O_MEM_WDATA(o_mem_wdata), .O_SP_PUSH(o_sp_push), .O_SP_POP(o_sp_pop), .O_PM_WE(o_pm_we),
    .O_PM_ADDR(o_pm_addr), .O_PM_WDATA(o_pm_wdata), .O_SLEEP_REQ(o_sleep_req),
    .O_BREAK_REQ(o_break_req), .O_WATCHDOG_RESTART_REQ(o_watchdog_restart_req));

  // 20 MHz clock and a free cycle count for completion timing
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    $display("[ERR] %0t %s", $time, s);
    num_errors++;
  endtask : fail

  task automatic complete_run();
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  // expected outcome of one instruction; also advances the flag model
  function automatic cpubt_obs_t model(input cpubt_pkg::cpubt_op_t op);
    cpubt_obs_t e;
    logic [7:0] r;
    logic c;
    e = '0;
    r = rd_v;
    c = rd_v[0];
    case (op)
      cpubt_pkg::OP_PROGRAM_MEMORY_STORE: begin
        e.pm_we = 1'b1; e.pm_a = {pg_v, z_v}; e.pm_d = r10_v;
        e.z_we = 1'b1; e.z_d = z_v + `CPUBT_PM_ZSTEP;
      end
      cpubt_pkg::OP_IO_IN: begin e.rd_we = 1'b1; e.rd_d = iod_v; end
      cpubt_pkg::OP_IO_OUT: begin e.io_we = 1'b1; e.io_a = io_v; e.io_d = rd_v; end
      cpubt_pkg::OP_IO_BIT_SET, cpubt_pkg::OP_IO_BIT_CLEAR: begin
        e.io_we = 1'b1; e.io_a = io_v;
        e.io_d = (op == cpubt_pkg::OP_IO_BIT_SET) ? (iod_v | (8'h01 << bs_v)) :
                 (iod_v & ~(8'h01 << bs_v));
      end
      cpubt_pkg::OP_PUSH: begin e.mem_we = 1'b1; e.mem_a = sp_v; e.mem_d = rd_v; e.push = 1'b1; end
      cpubt_pkg::OP_POP: begin e.rd_we = 1'b1; e.rd_d = md_v; end
      cpubt_pkg::OP_MEMORY_EXCHANGE, cpubt_pkg::OP_LOAD_AND_SET_MEMORY,
      cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY, cpubt_pkg::OP_LOAD_AND_TOGGLE_MEMORY: begin
        e.rd_we = 1'b1; e.rd_d = md_v; e.mem_we = 1'b1; e.mem_a = z_v;
        e.mem_d = (op == cpubt_pkg::OP_MEMORY_EXCHANGE) ? rd_v :
                  (op == cpubt_pkg::OP_LOAD_AND_SET_MEMORY) ? (rd_v | md_v) :
                  (op == cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY) ? (md_v & ~rd_v) : (rd_v ^ md_v);
      end
      cpubt_pkg::OP_LOGICAL_LEFT_SHIFT, cpubt_pkg::OP_ROTATE_LEFT_CARRY,
      cpubt_pkg::OP_LOGICAL_RIGHT_SHIFT, cpubt_pkg::OP_ROTATE_RIGHT_CARRY,
      cpubt_pkg::OP_ARITH_RIGHT_SHIFT: begin
        if (op == cpubt_pkg::OP_LOGICAL_LEFT_SHIFT) r = {rd_v[6:0], 1'b0};
        if (op == cpubt_pkg::OP_ROTATE_LEFT_CARRY) r = {rd_v[6:0], sr_m[`CPUBT_SR_C]};
        if (op == cpubt_pkg::OP_LOGICAL_RIGHT_SHIFT) r = {1'b0, rd_v[7:1]};
        if (op == cpubt_pkg::OP_ROTATE_RIGHT_CARRY) r = {sr_m[`CPUBT_SR_C], rd_v[7:1]};
        if (op == cpubt_pkg::OP_ARITH_RIGHT_SHIFT) r = {rd_v[7], rd_v[7:1]};
        if (op inside {cpubt_pkg::OP_LOGICAL_LEFT_SHIFT, cpubt_pkg::OP_ROTATE_LEFT_CARRY}) begin
          c = rd_v[7];
          sr_m[`CPUBT_SR_H] = rd_v[3];
        end
        sr_m[`CPUBT_SR_C] = c; sr_m[`CPUBT_SR_Z] = (r == 8'h00);
        sr_m[`CPUBT_SR_N] = r[7]; sr_m[`CPUBT_SR_V] = r[7] ^ c;
        e.rd_we = 1'b1; e.rd_d = r;
      end
      cpubt_pkg::OP_SWAP: begin e.rd_we = 1'b1; e.rd_d = {rd_v[3:0], rd_v[7:4]}; end
      cpubt_pkg::OP_BIT_TO_COPY_FLAG: sr_m[`CPUBT_SR_T] = rd_v[bs_v];
      cpubt_pkg::OP_COPY_FLAG_TO_BIT: begin
        r[bs_v] = sr_m[`CPUBT_SR_T]; e.rd_we = 1'b1; e.rd_d = r;
      end
      cpubt_pkg::OP_FLAG_SET: sr_m[bs_v] = 1'b1;
      cpubt_pkg::OP_FLAG_CLEAR: sr_m[bs_v] = 1'b0;
      cpubt_pkg::OP_GLOBAL_IRQ_ON: sr_m[`CPUBT_SR_I] = 1'b1;
      cpubt_pkg::OP_GLOBAL_IRQ_OFF: sr_m[`CPUBT_SR_I] = 1'b0;
      cpubt_pkg::OP_SLEEP: e.req = 3'b100;
      cpubt_pkg::OP_BREAK: e.req = 3'b010;
      cpubt_pkg::OP_WATCHDOG_RESTART: e.req = 3'b001;
      default: e.req = 3'b000;
    endcase
    e.sr = sr_m;
    return e;
  endfunction : model

  // issue one instruction; read ops wait out their memory answer, others run back to back or, at random, after an idle cycle and a 3-cycle enable freeze
  task automatic run(input cpubt_pkg::cpubt_op_t op, input int stall, input logic xtra,
                     input int b);
    bit rd_op;
    int lat;
    int gap;
    rd_op = op inside {cpubt_pkg::OP_POP, cpubt_pkg::OP_MEMORY_EXCHANGE,
      cpubt_pkg::OP_LOAD_AND_SET_MEMORY, cpubt_pkg::OP_LOAD_AND_CLEAR_MEMORY,
      cpubt_pkg::OP_LOAD_AND_TOGGLE_MEMORY};
    lat = rd_op ? 2 + int'(xtra) + stall : 1;
    gap = (!rd_op && $urandom_range(7) == 0) ? 3 : 0;
    rd_v = $urandom; pg_v = $urandom; iod_v = $urandom; md_v = $urandom; io_v = $urandom;
    z_v = ($urandom_range(3) == 0) ? 16'hffff : 16'($urandom);
    r10_v = $urandom; sp_v = $urandom;
    bs_v = (b < 0) ? 3'($urandom) : 3'(b);
    @(posedge i_clk);
    if (gap != 0) begin
      // let the previous pulse be seen before the enable freeze
      i_valid <= 1'b0;
      @(posedge i_clk);
    end
    exp_q.push_back(model(op));
    due_q.push_back(cyc + 1 + lat + gap);
    i_valid <= 1'b1; i_op <= op; i_sram_xtra <= xtra; i_bit_sel <= bs_v; i_io_addr <= io_v;
    i_rd_data <= rd_v; i_extended_z_page <= pg_v; i_io_rdata <= iod_v; i_z <= z_v;
    i_r1r0 <= r10_v; i_sp_addr <= sp_v;
    // a stalled memory shows junk until it answers
    i_mem_ready <= (stall == 0);
    i_mem_rdata <= (stall == 0) ? md_v : ~md_v;
    if (gap != 0) begin
      i_ce <= 1'b0;
      repeat (gap) @(posedge i_clk);
      i_ce <= 1'b1;
    end
    if (rd_op) begin
      for (int k = 1; k <= lat; k++) begin
        @(posedge i_clk);
        // request side of a read: busy throughout, read strobe until ready is seen
        if (k >= 2) begin
          samples_checked++;
          if (o_busy !== 1'b1 || o_mem_re !== 1'(k <= stall + 2))
            fail("read request mismatch");
          if (o_sp_pop !== 1'(k == 2 && op == cpubt_pkg::OP_POP))
            fail("pop strobe mismatch");
          if (o_mem_addr !== ((op == cpubt_pkg::OP_POP) ? sp_v : z_v))
            fail("read address mismatch");
        end
        if (k == 1) i_valid <= 1'b0;
        if (k == stall + 1) begin
          i_mem_ready <= 1'b1;
          i_mem_rdata <= md_v;
        end
      end
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: every completion is matched with the oldest note
  always @(posedge i_clk) begin : watch
    cpubt_obs_t e, o;
    int d;
    o = {o_rd_we, o_rd_we ? o_rd_wdata : 8'h00, o_status_register, o_mem_we,
         o_mem_we ? o_mem_wdata : 8'h00, o_mem_we ? o_mem_addr : 16'h0000, o_io_we,
         o_io_we ? o_io_addr : 6'h00, o_io_we ? o_io_wdata : 8'h00, o_pm_we,
         o_pm_we ? o_pm_addr : 24'h00_0000, o_pm_we ? o_pm_wdata : 16'h0000, o_z_we,
         o_z_we ? o_z_wdata : 16'h0000, o_sp_push, o_sleep_req, o_break_req,
         o_watchdog_restart_req};
    if (!i_srst && i_ce) begin
      if (o_done === 1'b1) begin
        samples_checked++;
        if (exp_q.size() == 0) fail("completion without a request");
        else begin
          e = exp_q.pop_front();
          d = due_q.pop_front();
          if (o !== e) fail("result mismatch");
          if (cyc != d) fail("completion cycle mismatch");
        end
      end else if ({o_rd_we, o_mem_we, o_io_we, o_pm_we, o_z_we, o_sleep_req, o_break_req,
                    o_watchdog_restart_req} !== 8'h00) begin
        fail("write or request outside completion");
      end
    end
  end

  // hang guard, well beyond the expected run
  initial begin
    #(50 * 20000);
    fail("timeout");
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(82841));
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    samples_checked++;
    if (o_status_register !== `CPUBT_SR_RST) fail("status register reset value");
    // every operation code once
    for (int k = 0; k <= 26; k++) begin
      run(cpubt_pkg::cpubt_op_t'(k), 0, 1'b0, -1);
    end
    // each status bit set then cleared on its own
    for (int k = 0; k < 8; k++) run(cpubt_pkg::OP_FLAG_SET, 0, 1'b0, k);
    for (int k = 0; k < 8; k++) run(cpubt_pkg::OP_FLAG_CLEAR, 0, 1'b0, k);
    // read ops with memory stalls and the extra internal cycle
    for (int k = 5; k <= 9; k++) begin
      run(cpubt_pkg::cpubt_op_t'(k), 0, 1'b1, -1);
      run(cpubt_pkg::cpubt_op_t'(k), 3, 1'b0, -1);
      run(cpubt_pkg::cpubt_op_t'(k), 2, 1'b1, -1);
    end
    // random mix, single-cycle ops back to back or after an idle cycle and an enable freeze
    for (int k = 0; k < 400; k++) begin
      run(cpubt_pkg::cpubt_op_t'($urandom_range(26)), $urandom_range(2), 1'($urandom),
          -1);
    end
    @(posedge i_clk);
    i_valid <= 1'b0;
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge i_clk);
    if (exp_q.size() != 0) fail("requests left without completion");
    complete_run();
  end
endmodule : cpu_bit_transfer_control_ops_test
`default_nettype wire
